// file: verilog/rst_pwr_pkg.sv
// Constants, register map and carrier types of the reset and power sequencer.
package rst_pwr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
	localparam logic [7:0] OFS_WDT_CTRL = 8'h04;
	localparam logic [7:0] OFS_IRQ_CFG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam int POWER_CONTROL_REG_IDLE_BIT = 0;
	localparam int POWER_CONTROL_REG_PD_BIT = 1;
	localparam int WDT_RST_EN_BIT = 0;
	localparam int WDT_IRQ_EN_BIT = 1;
	localparam int WDT_CLEAR_BIT = 2;
	localparam int STAT_POR_BIT = 0;
	localparam int STAT_WDT_RST_BIT = 1;
	localparam int STAT_WD_IRQ_BIT = 2;
	localparam int STAT_MODE_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] POWER_CONTROL_REG_RESET = 2'h0;
	localparam logic [1:0] WDT_CTRL_RESET = 2'h0;
	localparam int CLK_PERIOD_NS = 10;
	localparam logic [1:0] FOURTH_CLOCK_STATE = 2'h3;
	localparam logic [2:0] EXT_MIN_SAMPLES = 3'h6;
	localparam logic [1:0] EXT_TAIL_MC = 2'h3;
	localparam int WDT_GRACE_CLOCKS = 512;
	localparam int WDT_RST_CLOCKS = 30;
	localparam int POR_CLOCKS = 65536;
	localparam int WAKE_CLOCKS = 65536;
	localparam int WDT_INTERVAL_CLOCKS = 131072;

	typedef struct packed {
		logic ext1_edge;
		logic ext1_en;
		logic ext0_edge;
		logic ext0_en;
		logic global_irq_enable;
	} irq_cfg_t;
	localparam irq_cfg_t IRQ_CFG_RESET = 5'h00;

	typedef struct packed {
		logic ale;
		logic prog_fetch_strobe_n;
		logic port0_oe;
		logic [31:0] port;
	} pins_t;
	localparam pins_t PINS_RESET = {1'b1, 1'b1, 1'b0, 32'hffffffff};

	typedef enum logic [3:0] {
		MODE_RUN = 4'b0001,
		MODE_IDLE = 4'b0010,
		MODE_PDOWN = 4'b0100,
		MODE_WAKE = 4'b1000
	} mode_t;
endpackage

// file: verilog/reset_and_power_mode_sequencer.sv
// Reset merging, watchdog and idle/power-down sequencing with AXI4-Lite access.
`timescale 1ns/1ps
// Function
// - after power-on hold core reset 65,536 clocks before release.
// - supply below threshold sets power-on flag and holds reset meanwhile.
// - sample the external reset once per machine cycle, in fourth state.
// - accept external reset only after six consecutive high samples; in power-down the code takes a high synchronised input at once.
// - internal reset is generated synchronously from the sampled input.
// - stay in reset while input high, then up to three machine cycles.
// - external reset sets no cause flag.
// - watchdog runs freely; a software clear restarts its interval.
// - time-out sets flag; reset 512 clocks later if enabled and uncleared.
// - watchdog reset lasts thirty clocks, then execution restarts at zero.
// - idle bit enters idle after the instruction; CPU clock stops.
// - in idle strobes are high and port pins keep their entry levels.
// - any enabled interrupt clears the idle bit and leaves idle.
// - reset in idle restarts at once with no stabilisation wait.
// - watchdog counts in idle; its interrupt wakes, reset follows later.
// - power-down bit stops all clocks after the instruction completes.
// - in power-down strobes low, ports show registers, port 0 may float.
// - external reset high ends power-down and restarts at zero.
// - watchdog cannot wake from power-down since its clock stops.
// - enabled level external interrupt low restarts oscillator if global on.
// - after 65,536-clock wake delay resume for the interrupt service.
module reset_and_power_mode_sequencer #(
	parameter int POR_CYCLES = rst_pwr_pkg::POR_CLOCKS,
	parameter int WAKE_CYCLES = rst_pwr_pkg::WAKE_CLOCKS,
	parameter int WDT_INTERVAL = rst_pwr_pkg::WDT_INTERVAL_CLOCKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [rst_pwr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rst_pwr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic supply_ok,
	input wire logic ext_reset_in,
	input wire logic ext_irq0_n,
	input wire logic ext_irq1_n,
	input wire logic irq_pending,
	input wire logic cpu_instr_done,
	input wire logic ext_prog_mem,
	input wire rst_pwr_pkg::pins_t core_pins,
	input wire logic [31:0] port_sfr,
	output rst_pwr_pkg::pins_t pins_out,
	output logic core_reset,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic osc_enable,
	output logic wdt_irq
);
	import rst_pwr_pkg::*;

	localparam logic [16:0] POR_LIM = 17'(POR_CYCLES);
	localparam logic [16:0] WAKE_LAST = 17'(WAKE_CYCLES - 1);
	localparam logic [23:0] WDT_LAST = 24'(WDT_INTERVAL - 1);
	localparam logic [9:0] GRACE_LAST = 10'(WDT_GRACE_CLOCKS - 1);
	localparam logic [4:0] WDT_RST_LAST = 5'(WDT_RST_CLOCKS - 1);

	mode_t mode_reg, mode_next;
	logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [3:0] wstrb_reg;
	logic do_write, wr_en, wdt_clear;
	logic [2:0] sts_w1c;
	logic [1:0] power_control_reg_reg;
	logic [1:0] wdt_ctrl_reg;
	irq_cfg_t irq_cfg_reg;
	logic por_flag_reg, wdt_rst_flag_reg, wd_flag_reg;
	logic [16:0] por_cnt_reg, wake_cnt_reg;
	logic por_busy;
	logic sync1_reg, sync2_reg;
	logic [1:0] mc_phase_reg, tail_cnt_reg;
	logic [2:0] ext_high_cnt_reg;
	logic ext_rst_active_reg, sample;
	logic [23:0] wdt_cnt_reg;
	logic [9:0] grace_cnt_reg;
	logic grace_active_reg, wdt_rst_active_reg;
	logic [4:0] wdt_rst_cnt_reg;
	logic wdt_run, wdt_timeout, grace_expire;
	logic idle_wake, pd_wake_req;
	pins_t pins_reg, frozen_reg;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.
	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
	assign wr_en = do_write && wstrb_reg[0];
	assign wdt_clear = wr_en && waddr_reg == OFS_WDT_CTRL &&
		wdata_reg[WDT_CLEAR_BIT];
	assign sts_w1c = (wr_en && waddr_reg == OFS_STATUS) ? wdata_reg[2:0] :
		3'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				waddr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_got_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			unique case (waddr_reg)
				OFS_POWER_CONTROL, OFS_WDT_CTRL, OFS_IRQ_CFG,
				OFS_STATUS: bresp_reg <= RESP_OKAY;
				default: bresp_reg <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h00000000;
			unique case (s_axi_araddr)
				OFS_POWER_CONTROL: rdata_reg[1:0] <= power_control_reg_reg;
				OFS_WDT_CTRL: rdata_reg[1:0] <= wdt_ctrl_reg;
				OFS_IRQ_CFG: rdata_reg[4:0] <= irq_cfg_reg;
				OFS_STATUS: begin
					rdata_reg[STAT_POR_BIT] <= por_flag_reg;
					rdata_reg[STAT_WDT_RST_BIT] <= wdt_rst_flag_reg;
					rdata_reg[STAT_WD_IRQ_BIT] <= wd_flag_reg;
					rdata_reg[STAT_MODE_LSB+:4] <= mode_reg;
				end
				default: rresp_reg <= RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers return to reset values on any core reset; the status flags do not.
	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset) begin
			power_control_reg_reg <= POWER_CONTROL_REG_RESET;
			wdt_ctrl_reg <= WDT_CTRL_RESET;
			irq_cfg_reg <= IRQ_CFG_RESET;
		end else begin
			if (wr_en && waddr_reg == OFS_POWER_CONTROL) begin
				power_control_reg_reg <= wdata_reg[1:0];
			end else if (mode_reg == MODE_IDLE && idle_wake) begin
				power_control_reg_reg[POWER_CONTROL_REG_IDLE_BIT] <= 1'b0;
			end else if (mode_reg == MODE_WAKE && wake_cnt_reg == WAKE_LAST) begin
				power_control_reg_reg[POWER_CONTROL_REG_PD_BIT] <= 1'b0;
			end
			if (wr_en && waddr_reg == OFS_WDT_CTRL) begin
				wdt_ctrl_reg <= wdata_reg[1:0];
			end
			if (wr_en && waddr_reg == OFS_IRQ_CFG) begin
				irq_cfg_reg <= wdata_reg[4:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_flag_reg <= 1'b1;
			wdt_rst_flag_reg <= 1'b0;
			wd_flag_reg <= 1'b0;
		end else begin
			if (!supply_ok) begin
				por_flag_reg <= 1'b1;
			end else if (sts_w1c[STAT_POR_BIT]) begin
				por_flag_reg <= 1'b0;
			end
			if (grace_expire && wdt_ctrl_reg[WDT_RST_EN_BIT]) begin
				wdt_rst_flag_reg <= 1'b1;
			end else if (sts_w1c[STAT_WDT_RST_BIT]) begin
				wdt_rst_flag_reg <= 1'b0;
			end
			if (wdt_timeout) begin
				wd_flag_reg <= 1'b1;
			end else if (sts_w1c[STAT_WD_IRQ_BIT]) begin
				wd_flag_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-on reset stretch.
	always_ff @(posedge aclk) begin
		if (!aresetn || !supply_ok) begin
			por_cnt_reg <= 17'h00000;
		end else if (por_busy) begin
			por_cnt_reg <= por_cnt_reg + 17'h00001;
		end
	end
	assign por_busy = por_cnt_reg != POR_LIM;
	assign core_reset = por_busy || ext_rst_active_reg || wdt_rst_active_reg;

	////////////////////////////////////////////////////////////////////////
	// External reset: synchroniser, machine-cycle sampling, tail stretch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			mc_phase_reg <= 2'h0;
		end else begin
			sync1_reg <= ext_reset_in;
			sync2_reg <= sync1_reg;
			mc_phase_reg <= mc_phase_reg + 2'h1;
		end
	end
	assign sample = mc_phase_reg == FOURTH_CLOCK_STATE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_high_cnt_reg <= 3'h0;
		end else if (sample) begin
			if (!sync2_reg) begin
				ext_high_cnt_reg <= 3'h0;
			end else if (ext_high_cnt_reg != EXT_MIN_SAMPLES) begin
				ext_high_cnt_reg <= ext_high_cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_rst_active_reg <= 1'b0;
			tail_cnt_reg <= 2'h0;
		end else if (mode_reg == MODE_PDOWN && sync2_reg) begin
			ext_rst_active_reg <= 1'b1;
			tail_cnt_reg <= 2'h0;
		end else if (sample && sync2_reg) begin
			tail_cnt_reg <= 2'h0;
			if (ext_high_cnt_reg == EXT_MIN_SAMPLES - 3'h1) begin
				ext_rst_active_reg <= 1'b1;
			end
		end else if (sample && ext_rst_active_reg) begin
			if (tail_cnt_reg == EXT_TAIL_MC - 2'h1) begin
				ext_rst_active_reg <= 1'b0;
			end else begin
				tail_cnt_reg <= tail_cnt_reg + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog: free-running interval, grace window and reset pulse.
	assign wdt_run = periph_clk_en && !core_reset;
	assign wdt_timeout = wdt_run && wdt_cnt_reg == WDT_LAST;
	assign grace_expire = grace_active_reg && wdt_run &&
		grace_cnt_reg == GRACE_LAST;
	assign wdt_irq = wd_flag_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset || wdt_clear) begin
			wdt_cnt_reg <= 24'h000000;
		end else if (wdt_run) begin
			wdt_cnt_reg <= wdt_timeout ? 24'h000000 : wdt_cnt_reg + 24'h000001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset || wdt_clear) begin
			grace_active_reg <= 1'b0;
			grace_cnt_reg <= 10'h000;
		end else if (wdt_timeout && !grace_active_reg) begin
			grace_active_reg <= 1'b1;
			grace_cnt_reg <= 10'h000;
		end else if (grace_expire) begin
			grace_active_reg <= 1'b0;
		end else if (grace_active_reg && wdt_run) begin
			grace_cnt_reg <= grace_cnt_reg + 10'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_rst_active_reg <= 1'b0;
			wdt_rst_cnt_reg <= 5'h00;
		end else if (wdt_rst_active_reg) begin
			if (wdt_rst_cnt_reg == WDT_RST_LAST) begin
				wdt_rst_active_reg <= 1'b0;
			end
			wdt_rst_cnt_reg <= wdt_rst_cnt_reg + 5'h01;
		end else if (grace_expire && wdt_ctrl_reg[WDT_RST_EN_BIT]) begin
			wdt_rst_active_reg <= 1'b1;
			wdt_rst_cnt_reg <= 5'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power mode sequencer.
	assign idle_wake = irq_pending ||
		(wd_flag_reg && wdt_ctrl_reg[WDT_IRQ_EN_BIT]);
	assign pd_wake_req = irq_cfg_reg.global_irq_enable &&
		((irq_cfg_reg.ext0_en && !irq_cfg_reg.ext0_edge && !ext_irq0_n) ||
		(irq_cfg_reg.ext1_en && !irq_cfg_reg.ext1_edge && !ext_irq1_n));

	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			MODE_RUN: begin
				if (cpu_instr_done && power_control_reg_reg[POWER_CONTROL_REG_PD_BIT]) begin
					mode_next = MODE_PDOWN;
				end else if (cpu_instr_done && power_control_reg_reg[POWER_CONTROL_REG_IDLE_BIT]) begin
					mode_next = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (idle_wake) begin
					mode_next = MODE_RUN;
				end
			end
			MODE_PDOWN: begin
				if (pd_wake_req) begin
					mode_next = MODE_WAKE;
				end
			end
			MODE_WAKE: begin
				if (wake_cnt_reg == WAKE_LAST) begin
					mode_next = MODE_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset) begin
			mode_reg <= MODE_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || mode_reg != MODE_WAKE) begin
			wake_cnt_reg <= 17'h00000;
		end else begin
			wake_cnt_reg <= wake_cnt_reg + 17'h00001;
		end
	end

	assign cpu_clk_en = mode_reg == MODE_RUN;
	assign periph_clk_en = mode_reg == MODE_RUN || mode_reg == MODE_IDLE;
	assign osc_enable = mode_reg != MODE_PDOWN;

	////////////////////////////////////////////////////////////////////////
	// Pin states per mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frozen_reg <= PINS_RESET;
		end else if (mode_reg == MODE_RUN && mode_next == MODE_IDLE) begin
			frozen_reg <= core_pins;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_reg <= PINS_RESET;
		end else begin
			unique case (mode_reg)
				MODE_RUN: pins_reg <= core_pins;
				MODE_IDLE: begin
					pins_reg <= frozen_reg;
					pins_reg.ale <= 1'b1;
					pins_reg.prog_fetch_strobe_n <= 1'b1;
				end
				MODE_PDOWN, MODE_WAKE: begin
					pins_reg.ale <= 1'b0;
					pins_reg.prog_fetch_strobe_n <= 1'b0;
					pins_reg.port <= port_sfr;
					pins_reg.port0_oe <= !ext_prog_mem;
				end
			endcase
		end
	end
	assign pins_out = pins_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_por_release: assert property ($fell(por_busy) |->
		$past(por_cnt_reg) == POR_LIM - 17'h00001)
		else $error("power-on stretch ended early");
	a_supply_fail: assert property (!supply_ok |=> por_flag_reg && core_reset)
		else $error("supply failure did not hold reset");
	a_sample_phase: assert property ($changed(ext_high_cnt_reg) |->
		$past(mc_phase_reg) == FOURTH_CLOCK_STATE)
		else $error("external reset sampled off phase");
	a_ext_accept: assert property ($rose(ext_rst_active_reg) &&
		$past(mode_reg) != MODE_PDOWN |->
		$past(ext_high_cnt_reg) == EXT_MIN_SAMPLES - 3'h1)
		else $error("external reset accepted too soon");
	a_ext_hold: assert property (ext_rst_active_reg && sync2_reg |=>
		ext_rst_active_reg)
		else $error("reset released while input high");
	a_ext_noflag: assert property ($rose(ext_rst_active_reg) &&
		!grace_expire |=> !$rose(wdt_rst_flag_reg))
		else $error("external reset set a cause flag");
	a_wdt_clear: assert property (wdt_clear |=> wdt_cnt_reg == 24'h000000)
		else $error("watchdog clear did not restart count");
	a_wdt_grace: assert property ($rose(wdt_rst_active_reg) |->
		$past(grace_cnt_reg) == GRACE_LAST)
		else $error("watchdog reset not 512 clocks after flag");
	a_wdt_len: assert property ($rose(wdt_rst_active_reg) |->
		##29 wdt_rst_active_reg ##1 !wdt_rst_active_reg)
		else $error("watchdog reset not thirty clocks");
	a_idle_clocks: assert property ($rose(mode_reg == MODE_IDLE) |->
		$past(cpu_instr_done) && $past(power_control_reg_reg[POWER_CONTROL_REG_IDLE_BIT]) &&
		!cpu_clk_en && periph_clk_en)
		else $error("idle clock gating wrong");
	a_idle_pins: assert property (mode_reg == MODE_IDLE ##1
		mode_reg == MODE_IDLE |-> pins_out.ale && pins_out.prog_fetch_strobe_n
		&& pins_out.port == frozen_reg.port)
		else $error("idle pin state wrong");
	a_pdown_pins: assert property (mode_reg == MODE_PDOWN ##1
		mode_reg == MODE_PDOWN |-> !pins_out.ale && !osc_enable &&
		pins_out.port == $past(port_sfr))
		else $error("power-down pin state wrong");
	a_pdown_wdt: assert property (mode_reg == MODE_PDOWN |=>
		$stable(wdt_cnt_reg) || core_reset)
		else $error("watchdog ran in power-down");
	a_wake_len: assert property (mode_reg == MODE_RUN &&
		$past(mode_reg) == MODE_WAKE && !$past(core_reset) |->
		$past(wake_cnt_reg) == WAKE_LAST)
		else $error("cpu clock during wake delay");

	c_idle_wake: cover property (mode_reg == MODE_IDLE ##1
		mode_reg == MODE_RUN);
	c_pdown_wake: cover property (mode_reg == MODE_WAKE ##1
		mode_reg == MODE_RUN);
	c_wdt_reset: cover property ($rose(wdt_rst_active_reg));
	c_ext_reset: cover property ($rose(ext_rst_active_reg));
endmodule

// file: verif/core_model.sv
// Behavioural model of the CPU core that sits beside the sequencer.
`timescale 1ns/1ps
module core_model
	import rst_pwr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cpu_clk_en,
	input wire logic core_reset,
	output logic cpu_instr_done,
	output rst_pwr_pkg::pins_t core_pins
);
	logic [1:0] phase_reg = 2'h0;
	logic [7:0] cnt_reg = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// One instruction ends every four clocks while the core clock runs.
	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset || !cpu_clk_en) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign cpu_instr_done = cpu_clk_en && !core_reset && phase_reg == 2'h3;
	////////////////////////////////////////////////////////////////////////
	// The strobes toggle and the port value changes every clock so that a frozen output is visible.
	always_ff @(posedge aclk) begin
		cnt_reg <= cnt_reg + 8'h01;
	end
	assign core_pins = {cnt_reg[0], ~cnt_reg[0], 1'b1, {4{cnt_reg}}};
endmodule

// file: verif/reset_and_power_mode_sequencer_test.sv
// Self-checking testbench of the reset and power sequencer.
`timescale 1ns/1ps
module reset_and_power_mode_sequencer_test;
	import rst_pwr_pkg::*;
	localparam int POR = 16;
	localparam int WAKE = 16;
	localparam int WDI = 64;
	logic aclk;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, port_sfr = 32'h0, rdata, rd, snap;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic supply_ok = 1, ext_reset_in = 0, ext_irq0_n = 1, ext_irq1_n = 1;
	logic irq_pending = 0, ext_prog_mem = 0, cpu_instr_done;
	logic core_reset, cpu_clk_en, periph_clk_en, osc_enable, wdt_irq;
	pins_t core_pins, pins_out;
	int fail_count = 0, compares = 0, n;
	////////////////////////////////////////////////////////////////////////
	reset_and_power_mode_sequencer #(.POR_CYCLES(POR), .WAKE_CYCLES(WAKE),
		.WDT_INTERVAL(WDI)) reset_and_power_mode_sequencer_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .supply_ok(supply_ok),
		.ext_reset_in(ext_reset_in), .ext_irq0_n(ext_irq0_n),
		.ext_irq1_n(ext_irq1_n), .irq_pending(irq_pending),
		.cpu_instr_done(cpu_instr_done), .ext_prog_mem(ext_prog_mem),
		.core_pins(core_pins), .port_sfr(port_sfr), .pins_out(pins_out),
		.core_reset(core_reset), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
		.wdt_irq(wdt_irq));
	core_model core_model_inst (.aclk(aclk), .aresetn(aresetn),
		.cpu_clk_en(cpu_clk_en), .core_reset(core_reset),
		.cpu_instr_done(cpu_instr_done), .core_pins(core_pins));
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask
	function logic sig(input int s);
		case (s)
			0: return core_reset;
			1: return cpu_clk_en;
			2: return osc_enable;
			default: return wdt_irq;
		endcase
	endfunction
	task wait_lvl(input int s, input logic lvl, input int lim, output int k);
		k = 0;
		while (sig(s) !== lvl && k < lim) begin
			@(posedge aclk);
			#1;
			k++;
		end
		chk($sformatf("wait on signal %0d", s), 32'(lvl), 32'(sig(s)));
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ga, gw, gb, aok, wok;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		aok = 0;
		wok = 0;
		do begin
			#1;
			ga = awvalid && awready;
			gw = wvalid && wready;
			gb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ga) begin
				awvalid <= 0;
				aok = 1;
			end
			if (gw) begin
				wvalid <= 0;
				wok = 1;
			end
		end while (!gb);
		bready <= 0;
		chk("write answer", 32'h3, {30'h0, aok, wok});
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ga, gr, aok;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		aok = 0;
		do begin
			#1;
			ga = arvalid && arready;
			gr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ga) begin
				arvalid <= 0;
				aok = 1;
			end
		end while (!gr);
		rready <= 0;
		chk("read answer", 32'h1, 32'(aok));
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_por;
		wait_lvl(0, 0, POR + 10, n);
		chk("power-on hold", 32'h1, 32'(n >= POR && n <= POR + 3));
		axi_rd(OFS_STATUS, rd, rsp);
		chk("power-on flag", 32'h1, 32'(rd[STAT_POR_BIT]));
		chk("run mode", {28'h0, MODE_RUN}, {28'h0, rd[11:8]});
	endtask
	task t_supply;
		axi_wr(OFS_STATUS, 32'h7, rsp);
		@(posedge aclk);
		supply_ok <= 0;
		tick(20);
		chk("reset in brownout", 32'h1, 32'(core_reset));
		@(posedge aclk);
		supply_ok <= 1;
		wait_lvl(0, 0, POR + 10, n);
		chk("hold after brownout", 32'h1, 32'(n >= POR));
		axi_rd(OFS_STATUS, rd, rsp);
		chk("brownout flag", 32'h1, 32'(rd[STAT_POR_BIT]));
		axi_wr(OFS_STATUS, 32'h7, rsp);
	endtask
	task t_ext;
		@(posedge aclk);
		ext_reset_in <= 1;
		repeat (12) @(posedge aclk);
		ext_reset_in <= 0;
		n = 0;
		repeat (30) begin
			@(posedge aclk);
			#1;
			n += int'(core_reset);
		end
		chk("short pulse ignored", 32'h0, 32'(n));
		@(posedge aclk);
		ext_reset_in <= 1;
		repeat (40) @(posedge aclk);
		#1;
		chk("ext reset taken", 32'h1, 32'(core_reset));
		@(posedge aclk);
		ext_reset_in <= 0;
		#1;
		chk("held while high", 32'h1, 32'(core_reset));
		wait_lvl(0, 0, 24, n);
		chk("release tail", 32'h1, 32'(n >= 4 && n <= 20));
		axi_rd(OFS_STATUS, rd, rsp);
		chk("no cause flag", 32'h0, 32'(rd[1:0]));
	endtask
	task t_wdt;
		axi_wr(OFS_WDT_CTRL, 32'h4, rsp);
		axi_wr(OFS_STATUS, 32'h4, rsp);
		repeat (3) begin
			tick(40);
			axi_wr(OFS_WDT_CTRL, 32'h4, rsp);
		end
		chk("cleared watchdog quiet", 32'h0, 32'(wdt_irq));
		axi_wr(OFS_WDT_CTRL, 32'h5, rsp);
		wait_lvl(3, 1, WDI + 10, n);
		wait_lvl(0, 1, 530, n);
		chk("grace period", 32'h1, 32'(n >= 510 && n <= 513));
		wait_lvl(0, 0, 40, n);
		chk("watchdog reset length", 32'h1, 32'(n >= 29 && n <= 31));
		axi_rd(OFS_STATUS, rd, rsp);
		chk("watchdog cause", 32'h6, 32'(rd[2:0]));
		axi_wr(OFS_STATUS, 32'h7, rsp);
	endtask
	task t_idle;
		axi_wr(OFS_POWER_CONTROL, 32'h1, rsp);
		wait_lvl(1, 0, 20, n);
		chk("peripherals run", 32'h1, 32'(periph_clk_en));
		tick(1);
		snap = pins_out.port;
		chk("idle strobes", 32'h3,
			32'({pins_out.ale, pins_out.prog_fetch_strobe_n}));
		tick(8);
		chk("idle port frozen", snap, pins_out.port);
		@(posedge aclk);
		irq_pending <= 1;
		wait_lvl(1, 1, 20, n);
		@(posedge aclk);
		irq_pending <= 0;
		axi_rd(OFS_POWER_CONTROL, rd, rsp);
		chk("idle bit cleared", 32'h0, 32'(rd[0]));
	endtask
	task t_pdown;
		@(posedge aclk);
		ext_prog_mem <= 1;
		port_sfr <= 32'h5a5ac3c3;
		axi_wr(OFS_IRQ_CFG, 32'h3, rsp);
		axi_wr(OFS_WDT_CTRL, 32'h7, rsp);
		axi_wr(OFS_POWER_CONTROL, 32'h2, rsp);
		wait_lvl(2, 0, 20, n);
		tick(2);
		chk("pdown clocks", 32'h0, 32'({cpu_clk_en, periph_clk_en}));
		chk("pdown strobes", 32'h0,
			32'({pins_out.ale, pins_out.prog_fetch_strobe_n}));
		chk("pdown port0 float", 32'h0, 32'(pins_out.port0_oe));
		chk("pdown port", port_sfr, pins_out.port);
		tick(WDI * 3);
		chk("no watchdog wake", 32'h0, 32'({osc_enable, core_reset}));
		@(posedge aclk);
		ext_irq0_n <= 0;
		wait_lvl(2, 1, 10, n);
		wait_lvl(1, 1, WAKE + 10, n);
		chk("wake delay", 32'h1, 32'(n >= WAKE - 2 && n <= WAKE + 2));
		@(posedge aclk);
		ext_irq0_n <= 1;
		axi_wr(OFS_WDT_CTRL, 32'h4, rsp);
		axi_rd(OFS_POWER_CONTROL, rd, rsp);
		chk("pdown bit cleared", 32'h0, 32'(rd[1:0]));
	endtask
	task t_pd_reset;
		axi_wr(OFS_WDT_CTRL, 32'h7, rsp);
		axi_wr(OFS_POWER_CONTROL, 32'h2, rsp);
		wait_lvl(2, 0, 20, n);
		@(posedge aclk);
		ext_reset_in <= 1;
		wait_lvl(0, 1, 8, n);
		tick(1);
		chk("clock restarted", 32'h1, 32'(osc_enable));
		@(posedge aclk);
		ext_reset_in <= 0;
		wait_lvl(0, 0, 40, n);
		axi_rd(OFS_POWER_CONTROL, rd, rsp);
		chk("pdown bit after reset", 32'h0, rd);
	endtask
	task t_unmapped;
		axi_wr(8'h10, 32'hffffffff, rsp);
		chk("unmapped write", 32'(RESP_SLVERR), 32'(rsp));
		axi_rd(8'h10, rd, rsp);
		chk("unmapped read", 32'(RESP_SLVERR), 32'(rsp));
		chk("unmapped data", 32'h0, rd);
		axi_rd(OFS_WDT_CTRL, rd, rsp);
		chk("control after reset", 32'h0, rd);
	endtask
	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_por;
		t_supply;
		t_ext;
		t_wdt;
		t_idle;
		t_pdown;
		t_pd_reset;
		t_unmapped;
		tally_and_finish;
	end
endmodule
